// ### core/icsm_defines.svh
// Purpose: offsets, bit positions, reset values and timing for icsm
// Assumes: 32-bit APB data, one register per aligned word
// Notes: included by the design file and the bench
`ifndef ICSM_DEFINES_SVH
`define ICSM_DEFINES_SVH

`define ICSM_OFS_CTL 8'h00
`define ICSM_OFS_STAT 8'h04
`define ICSM_OFS_MASK 8'h08
`define ICSM_OFS_THR 8'h0c
`define ICSM_OFS_RHR 8'h10
`define ICSM_OFS_OWN 8'h14

`define ICSM_C_EN 15
`define ICSM_C_ACCALL 11
`define ICSM_C_TEN 10
`define ICSM_C_GCEN 7
`define ICSM_C_ACKV 5
`define ICSM_C_ACKGO 4
`define ICSM_C_RXGO 3
`define ICSM_C_STOPGO 2
`define ICSM_C_RSGO 1
`define ICSM_C_STGO 0

`define ICSM_S_ACKST 15
`define ICSM_S_TXACT 14
`define ICSM_S_BCL 10
`define ICSM_S_GC 9
`define ICSM_S_TEN 8
`define ICSM_S_WCOL 7
`define ICSM_S_POV 6
`define ICSM_S_DA 5
`define ICSM_S_P 4
`define ICSM_S_S 3
`define ICSM_S_RW 2
`define ICSM_S_RBF 1
`define ICSM_S_TBF 0

`define ICSM_RST_MASK 10'h000
`define ICSM_RST_OWN 10'h000
`define ICSM_GC_ADDR 8'h00
`define ICSM_TEN_HDR 5'h1e

`define ICSM_CLK_NS 10
`define ICSM_QTR_NS 2500
`define ICSM_QTR_CYC (`ICSM_QTR_NS / `ICSM_CLK_NS)

`endif

// ### core/icsm_pkg.sv
// Purpose: types for icsm
// Assumes: nothing
// Notes: master sequence states are one-hot
package icsm_pkg;
	typedef enum logic [6:0] {
		M_IDLE = 7'h01,
		M_START = 7'h02,
		M_RESTART = 7'h04,
		M_STOP = 7'h08,
		M_TX = 7'h10,
		M_RX = 7'h20,
		M_ACK = 7'h40
	} icsm_mst_e;

	typedef struct packed {
		logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
		logic en, acc_all, ten_mode, gc_en, ack_val;
		logic ack_go, rx_go, stop_go, rs_go, st_go;
		logic ack_stat, tx_act, collision_flag, gc_seen, ten_m, wcol, pov;
		logic d_a, p_seen, s_seen, rw, receive_full, transmit_full;
		logic [9:0] mask;
		logic [9:0] own;
		logic [7:0] thr;
		logic [7:0] rhr;
		icsm_mst_e m_st;
		logic [1:0] ph;
		logic [11:0] tmr;
		logic [3:0] bc;
		logic [7:0] sh;
		logic own_bus, scl_d, sda_d, mev;
		logic [3:0] s_cnt;
		logic [7:0] s_rsr;
		logic [1:0] s_idx;
		logic s_addr, s_hi_ok, s_pend, s_ack;
		logic [31:0] prdata;
	} icsm_state_s;
endpackage

// ### core/icsm_top.sv
// Purpose: two-wire bus controller control, status and address mask logic
// Assumes: bus lines are open drain, sampled through two flip-flops
// Notes: registers reached over APB with zero wait states
`timescale 1ns/10ps
`include "icsm_defines.svh"

module icsm_top
	import icsm_pkg::*;
#(
	parameter logic [11:0] QTR_CYC = 12'(`ICSM_QTR_CYC)
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// bus lines
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// master event pulse
	output logic master_event_o
);
	icsm_state_s q;
	icsm_state_s d;

	always_comb
	begin
		logic wr, rd, setup, rise, fall, st_det, sp_det, tick, stretch;
		logic push, hit;
		logic [7:0] pb;
		logic [7:0] b;
		logic [15:0] stat;
		wr = psel_i & penable_i & pwrite_i;
		rd = psel_i & penable_i & ~pwrite_i;
		setup = psel_i & ~penable_i;
		push = 1'b0;
		hit = 1'b0;
		pb = 8'h00;
		b = {q.s_rsr[6:0], q.sda_s};
		d = q;
		d.mev = 1'b0;
		// line synchronisers
		d.scl_m = scl_i;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = sda_i;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		rise = q.scl_s & ~q.scl_p;
		fall = ~q.scl_s & q.scl_p;
		st_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
		sp_det = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
		stat = {q.ack_stat, q.tx_act, 3'h0, q.collision_flag, q.gc_seen, q.ten_m,
			q.wcol, q.pov, q.d_a, q.p_seen, q.s_seen, q.rw, q.receive_full, q.transmit_full};

		// read data captured in the setup phase
		if (setup)
		begin
			unique case (paddr_i)
				`ICSM_OFS_CTL: d.prdata = {16'h0000, q.en, 3'h0, q.acc_all,
					q.ten_mode, 2'h0, q.gc_en, 1'b0, q.ack_val, q.ack_go,
					q.rx_go, q.stop_go, q.rs_go, q.st_go};
				`ICSM_OFS_STAT: d.prdata = {16'h0000, stat};
				`ICSM_OFS_MASK: d.prdata = {22'h000000, q.mask};
				`ICSM_OFS_THR: d.prdata = {24'h000000, q.thr};
				`ICSM_OFS_RHR: d.prdata = {24'h000000, q.rhr};
				`ICSM_OFS_OWN: d.prdata = {22'h000000, q.own};
				default: d.prdata = 32'h00000000;
			endcase
		end

		// software clears go first so that hardware sets win
		if (wr && paddr_i == `ICSM_OFS_STAT)
		begin
			d.collision_flag = q.collision_flag & pwdata_i[`ICSM_S_BCL];
			d.wcol = q.wcol & pwdata_i[`ICSM_S_WCOL];
			d.pov = q.pov & pwdata_i[`ICSM_S_POV];
			d.p_seen = q.p_seen & pwdata_i[`ICSM_S_P];
			d.s_seen = q.s_seen & pwdata_i[`ICSM_S_S];
		end
		if (rd && paddr_i == `ICSM_OFS_RHR)
			d.receive_full = 1'b0;
		if (wr && paddr_i == `ICSM_OFS_MASK)
			d.mask = pwdata_i[9:0];
		if (wr && paddr_i == `ICSM_OFS_OWN)
			d.own = pwdata_i[9:0];

		// start and stop detection
		if (st_det)
		begin
			d.s_seen = 1'b1;
			d.p_seen = 1'b0;
			d.s_cnt = 4'h0;
			d.s_idx = 2'h0;
			d.s_addr = 1'b0;
		end
		if (sp_det)
		begin
			d.p_seen = 1'b1;
			d.s_seen = 1'b0;
			d.gc_seen = 1'b0;
			d.ten_m = 1'b0;
			d.s_addr = 1'b0;
			d.s_hi_ok = 1'b0;
		end

		// slave byte reception and address recognition
		if (q.en && rise && !st_det && !sp_det)
		begin
			if (q.s_cnt == 4'h8)
				d.s_cnt = 4'h0;
			else
			begin
				d.s_rsr = b;
				d.s_cnt = q.s_cnt + 4'h1;
			end
			if (q.s_cnt == 4'h7 && !q.own_bus)
			begin
				d.s_idx = 2'h2;
				unique case (q.s_idx)
					2'h0:
					begin
						if (b == `ICSM_GC_ADDR && q.gc_en)
						begin
							d.gc_seen = 1'b1;
							d.s_addr = 1'b1;
							d.d_a = 1'b0;
							d.rw = 1'b0;
						end
						else if (q.ten_mode)
						begin
							hit = b[7:3] == `ICSM_TEN_HDR &&
								((b[2:1] ^ q.own[9:8]) & ~q.mask[9:8]) == 2'h0;
							if ((hit || q.acc_all) && b[0] && q.s_hi_ok)
							begin
								d.s_addr = 1'b1;
								d.d_a = 1'b0;
								d.rw = 1'b1;
							end
							else if ((hit || q.acc_all) && !b[0])
							begin
								d.s_idx = 2'h1;
								d.s_hi_ok = 1'b0;
							end
						end
						else
						begin
							hit = ((b[7:1] ^ q.own[6:0]) & ~q.mask[6:0]) ==
								7'h00;
							if (hit || q.acc_all)
							begin
								d.s_addr = 1'b1;
								d.d_a = 1'b0;
								d.rw = b[0];
							end
						end
					end
					2'h1:
					begin
						hit = ((b ^ q.own[7:0]) & ~q.mask[7:0]) == 8'h00;
						if (hit || q.acc_all)
						begin
							d.ten_m = 1'b1;
							d.s_hi_ok = 1'b1;
							d.s_addr = 1'b1;
							d.d_a = 1'b0;
							d.rw = 1'b0;
						end
					end
					default:
					begin
						if (q.s_addr && !q.rw)
						begin
							d.d_a = 1'b1;
							push = 1'b1;
							pb = b;
						end
					end
				endcase
				d.s_pend = d.s_addr;
			end
		end
		// slave acknowledge held for the ninth clock
		if (fall)
		begin
			d.s_ack = q.s_pend;
			d.s_pend = 1'b0;
		end

		// master sequencer
		stretch = q.scl_d & ~q.scl_s;
		tick = q.m_st != M_IDLE && !stretch && q.tmr == QTR_CYC - 12'h001;
		if (q.m_st != M_IDLE && !stretch)
			d.tmr = tick ? 12'h000 : q.tmr + 12'h001;
		if (tick)
			d.ph = q.ph + 2'h1;
		unique case (q.m_st)
			M_IDLE:
			begin
				d.ph = 2'h0;
				d.tmr = 12'h000;
				d.bc = 4'h0;
				// one trigger at a time is assumed; fixed priority otherwise
				if (q.en && q.st_go)
					d.m_st = M_START;
				else if (q.en && q.rs_go)
					d.m_st = M_RESTART;
				else if (q.en && q.stop_go)
					d.m_st = M_STOP;
				else if (q.en && q.rx_go)
					d.m_st = M_RX;
				else if (q.en && q.ack_go)
					d.m_st = M_ACK;
			end
			M_START, M_RESTART, M_STOP, M_ACK:
			begin
				if (tick && q.ph == 2'h3)
				begin
					d.m_st = M_IDLE;
					d.mev = 1'b1;
					d.st_go = q.m_st == M_START ? 1'b0 : q.st_go;
					d.rs_go = q.m_st == M_RESTART ? 1'b0 : q.rs_go;
					d.stop_go = q.m_st == M_STOP ? 1'b0 : q.stop_go;
					d.ack_go = q.m_st == M_ACK ? 1'b0 : q.ack_go;
					d.own_bus = q.m_st != M_STOP;
				end
			end
			M_TX:
			begin
				if (tick && q.ph == 2'h2)
				begin
					if (q.bc == 4'h8)
						d.ack_stat = q.sda_s;
					else if (q.sh[7] && !q.sda_s)
					begin
						d.collision_flag = 1'b1;
						d.m_st = M_IDLE;
						d.mev = 1'b1;
						d.own_bus = 1'b0;
						d.tx_act = 1'b0;
						d.transmit_full = 1'b0;
					end
				end
				if (tick && q.ph == 2'h3)
				begin
					d.bc = q.bc + 4'h1;
					d.sh = {q.sh[6:0], 1'b1};
					if (q.bc == 4'h8)
					begin
						d.m_st = M_IDLE;
						d.mev = 1'b1;
						d.tx_act = 1'b0;
						d.transmit_full = 1'b0;
					end
				end
			end
			M_RX:
			begin
				if (tick && q.ph == 2'h2)
					d.sh = {q.sh[6:0], q.sda_s};
				if (tick && q.ph == 2'h3)
				begin
					d.bc = q.bc + 4'h1;
					if (q.bc == 4'h7)
					begin
						d.rx_go = 1'b0;
						d.m_st = M_IDLE;
						d.mev = 1'b1;
						push = 1'b1;
						pb = q.sh;
					end
				end
			end
			default:
			begin
				d.m_st = M_IDLE;
			end
		endcase

		// move a finished byte into the receive holding register
		if (push)
		begin
			if (q.receive_full && !(rd && paddr_i == `ICSM_OFS_RHR))
				d.pov = 1'b1;
			else
			begin
				d.rhr = pb;
				d.receive_full = 1'b1;
			end
		end

		// software writes to control and transmit holding
		if (wr && paddr_i == `ICSM_OFS_CTL)
		begin
			d.en = pwdata_i[`ICSM_C_EN];
			d.acc_all = pwdata_i[`ICSM_C_ACCALL];
			d.ten_mode = pwdata_i[`ICSM_C_TEN];
			d.gc_en = pwdata_i[`ICSM_C_GCEN];
			d.ack_val = pwdata_i[`ICSM_C_ACKV];
			d.ack_go = pwdata_i[`ICSM_C_ACKGO];
			d.rx_go = pwdata_i[`ICSM_C_RXGO];
			d.stop_go = pwdata_i[`ICSM_C_STOPGO];
			d.rs_go = pwdata_i[`ICSM_C_RSGO];
			d.st_go = pwdata_i[`ICSM_C_STGO];
		end
		if (wr && paddr_i == `ICSM_OFS_THR)
		begin
			if (q.m_st != M_IDLE || q.transmit_full)
				d.wcol = 1'b1;
			else
			begin
				d.thr = pwdata_i[7:0];
				d.transmit_full = 1'b1;
				if (q.own_bus)
				begin
					d.m_st = M_TX;
					d.sh = pwdata_i[7:0];
					d.tx_act = 1'b1;
				end
			end
		end
		if (!d.en)
		begin
			d.m_st = M_IDLE;
			d.own_bus = 1'b0;
			d.tx_act = 1'b0;
		end

		// line drive from the next master state, 1 releases the line
		unique case (d.m_st)
			M_START:
			begin
				d.scl_d = d.ph[1] == 1'b0;
				d.sda_d = d.ph == 2'h0;
			end
			M_RESTART:
			begin
				d.scl_d = d.ph == 2'h1 || d.ph == 2'h2;
				d.sda_d = d.ph[1] == 1'b0;
			end
			M_STOP:
			begin
				d.scl_d = d.ph != 2'h0;
				d.sda_d = d.ph[1];
			end
			M_TX, M_RX, M_ACK:
			begin
				d.scl_d = d.ph == 2'h1 || d.ph == 2'h2;
				if (d.m_st == M_TX)
					d.sda_d = d.bc == 4'h8 ? 1'b1 : d.sh[7];
				else if (d.m_st == M_ACK)
					d.sda_d = d.ack_val;
				else
					d.sda_d = 1'b1;
			end
			default:
			begin
				d.scl_d = ~d.own_bus;
				d.sda_d = d.own_bus ? q.sda_d : 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.scl_m <= 1'b1;
			q.scl_s <= 1'b1;
			q.scl_p <= 1'b1;
			q.sda_m <= 1'b1;
			q.sda_s <= 1'b1;
			q.sda_p <= 1'b1;
			q.scl_d <= 1'b1;
			q.sda_d <= 1'b1;
			q.m_st <= M_IDLE;
			q.mask <= `ICSM_RST_MASK;
			q.own <= `ICSM_RST_OWN;
		end
		else
			q <= d;
	end

	assign prdata_o = q.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & (paddr_i[1:0] != 2'h0 ||
		paddr_i > `ICSM_OFS_OWN);
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n_o = q.scl_d;
	assign sda_oe_n_o = q.sda_d & ~q.s_ack;
	assign master_event_o = q.mev;

	logic wr_ctl, wr_thr, rd_rhr;
	assign wr_ctl = psel_i & penable_i & pwrite_i & paddr_i == `ICSM_OFS_CTL;
	assign wr_thr = psel_i & penable_i & pwrite_i & paddr_i == `ICSM_OFS_THR;
	assign rd_rhr = psel_i & penable_i & ~pwrite_i & paddr_i == `ICSM_OFS_RHR;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_value_drive_a: assert property (
		q.m_st == M_ACK && !q.s_ack |-> sda_oe_n_o == q.ack_val)
		else $error("acknowledge value not driven");
	ack_go_clear_a: assert property (
		q.m_st == M_ACK ##1 q.m_st == M_IDLE |-> !q.ack_go || $past(wr_ctl))
		else $error("acknowledge trigger not cleared");
	rx_go_clear_a: assert property (
		q.m_st == M_RX ##1 q.m_st == M_IDLE |-> !q.rx_go || $past(wr_ctl))
		else $error("receive trigger not cleared");
	stop_release_a: assert property (
		q.m_st == M_STOP ##1 q.m_st == M_IDLE |-> !q.own_bus && scl_oe_n_o)
		else $error("stop did not release bus");
	tx_active_a: assert property (
		q.m_st == M_TX |-> q.tx_act)
		else $error("transmit active low during transmit");
	collision_idle_a: assert property (
		$rose(q.collision_flag) |-> q.m_st == M_IDLE && master_event_o)
		else $error("collision did not idle master");
	seen_exclusive_a: assert property (
		!(q.p_seen && q.s_seen))
		else $error("start and stop both shown");
	rbf_read_clear_a: assert property (
		rd_rhr && !$past(rd_rhr) ##1 q.m_st == M_IDLE && !$rose(q.d_a)
		|-> !q.receive_full || q.pov == $past(q.pov))
		else $error("receive full not cleared by read");
	tbf_write_set_a: assert property (
		wr_thr && q.m_st == M_IDLE && !q.transmit_full |=> q.transmit_full && $stable(q.wcol))
		else $error("transmit full not set");
	wcol_busy_a: assert property (
		wr_thr && q.transmit_full |=> q.wcol)
		else $error("write collision not flagged");

	start_seq_c: cover property (q.m_st == M_START ##1 q.m_st == M_IDLE);
	tx_byte_c: cover property (q.m_st == M_TX && q.bc == 4'h8);
	slave_match_c: cover property ($rose(q.s_addr));
	overflow_c: cover property ($rose(q.pov));
endmodule

// ### dv/icsm_bus_model.sv
// Purpose: two-wire bus partner, slave responder and master
// Assumes: both lines pulled up; a pull output low-drives the line
// Notes: acks any address; read data comes from rd_byte_i
`timescale 1ns/10ps
module icsm_bus_model (
	// bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_pull_o,
	output logic sda_pull_o,
	// responder controls
	input wire logic nack_i,
	input wire logic [7:0] rd_byte_i,
	input wire logic coll_i,
	input wire logic stretch_i
);
	logic in_frame = 0, mst = 0, rd_dir = 0, ack_seen = 0;
	logic [7:0] sh = 0, last_byte = 0;
	int cnt = 0, nbyte = 0;
	initial
	begin
		scl_pull_o = 0;
		sda_pull_o = 0;
	end
	// start and stop: data edge while clock high
	always @(negedge sda_i)
		if (scl_i === 1'b1)
		begin
			in_frame = 1;
			cnt = 0;
			nbyte = 0;
			rd_dir = 0;
		end
	always @(posedge sda_i)
		if (scl_i === 1'b1)
			in_frame = 0;
	// sample on rising clock, msb first, ninth bit is acknowledge
	always @(posedge scl_i)
		if (in_frame)
		begin
			if (cnt < 8)
				sh = {sh[6:0], sda_i};
			else
			begin
				ack_seen = sda_i;
				last_byte = sh;
				if (nbyte == 0)
					rd_dir = sh[0];
				else if (sda_i)
					rd_dir = 0;
				nbyte++;
			end
			cnt = (cnt == 8) ? 0 : cnt + 1;
		end
	// drive after the falling clock; a nack from the master ends read data
	always @(negedge scl_i)
		if (in_frame && !mst)
		begin
			if (cnt == 8)
				sda_pull_o = !(rd_dir && nbyte > 0) && !nack_i;
			else if (rd_dir && nbyte > 0)
				sda_pull_o = !rd_byte_i[7 - cnt];
			else
				sda_pull_o = coll_i && nbyte == 0;
			if (cnt == 0 && stretch_i)
			begin
				scl_pull_o = 1;
				#400 scl_pull_o = 0;
			end
		end
	always @(negedge coll_i)
		sda_pull_o = 0;
	// master role, 160 ns bit, clock still outside frames
	task automatic m_start();
		mst = 1;
		#40 sda_pull_o = 1;
		#40 scl_pull_o = 1;
		#40;
	endtask
	task automatic m_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--)
		begin
			sda_pull_o = (i >= 0) ? !b[i] : 1'b0;
			#40 scl_pull_o = 0;
			wait (scl_i === 1'b1);
			#40 ack = sda_i;
			#40 scl_pull_o = 1;
			#40;
		end
	endtask
	task automatic m_stop();
		sda_pull_o = 1;
		#40 scl_pull_o = 0;
		wait (scl_i === 1'b1);
		#40 sda_pull_o = 0;
		#80 mst = 0;
	endtask
endmodule

// ### dv/i2c_control_status_mask_bench.sv
// Purpose: self-checking bench for icsm_top
// Assumes: bus model on pulled-up lines; quarter bit is 4 clocks
// Notes: registers reached through an apb master task
`timescale 1ns/10ps
`include "icsm_defines.svh"
module i2c_control_status_mask_bench;
	logic clk_i = 0, rst_i = 1;
	logic [7:0] paddr = 0, rdb = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, e, ack, mev;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_pull, sda_pull;
	logic nack = 0, coll = 0, str = 0;
	wire scl = (scl_oe_n | scl_o) & !scl_pull;
	wire sda = (sda_oe_n | sda_o) & !sda_pull;
	int n_fail = 0, samples_checked = 0;
	localparam logic [31:0] EN = 32'h8080;
	logic [7:0] ra [4] = '{`ICSM_OFS_MASK, `ICSM_OFS_OWN,
		`ICSM_OFS_MASK, `ICSM_OFS_CTL};
	logic [31:0] rw [4] = '{32'hffffffff, 32'hffffffff, 32'h0, EN};
	logic [31:0] rx [4] = '{32'h3ff, 32'h3ff, 32'h0, EN};
	always #5 clk_i = ~clk_i;
	icsm_top #(.QTR_CYC(12'h004)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .scl_i(scl),
		.scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .master_event_o(mev));
	icsm_bus_model bm (.scl_i(scl), .sda_i(sda), .scl_pull_o(scl_pull),
		.sda_pull_o(sda_pull), .nack_i(nack), .rd_byte_i(rdb),
		.coll_i(coll), .stretch_i(str));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1;
		@(posedge clk_i);
		while (pready !== 1'b1)
			@(posedge clk_i);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		chk(n, x, q & m);
	endtask
	task automatic sb(input string n, input int b, input logic x);
		rchk(n, `ICSM_OFS_STAT, 32'h1 << b, 32'(x) << b);
	endtask
	task automatic go(input int b, input logic [31:0] x);
		int i;
		wr(`ICSM_OFS_CTL, EN | x | (32'h1 << b));
		for (i = 0; i < 400; i++)
		begin
			apb(`ICSM_OFS_CTL, 1'b0, 32'h0);
			if (q[b] === 1'b0)
				break;
		end
		chk("go bit", 32'h0, 32'(q[b]));
	endtask
	task automatic wev();
		int i;
		for (i = 0; i < 3000 && mev !== 1'b1; i++)
			@(negedge clk_i);
		chk("master event", 32'h1, 32'(mev));
	endtask
	task automatic tdone(input string n);
		$display("test %s finished", n);
	endtask
	initial
	begin
		#600000;
		n_fail++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		foreach (ra[i])
		begin
			wr(ra[i], rw[i]);
			rchk("row", ra[i], 32'hffffffff, rx[i]);
		end
		tdone("register rows");
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		chk("sda released", 32'h1, 32'(sda_oe_n));
		foreach (ra[i])
			rchk("reset value", ra[i], 32'hffffffff, 32'h0);
		rchk("status reset", `ICSM_OFS_STAT, 32'hffffffff, 32'h0);
		wr(8'h18, 32'h1);
		chk("slverr", 32'h1, 32'(e));
		tdone("reset and unmapped");
		wr(`ICSM_OFS_OWN, 32'h52);
		go(`ICSM_C_STGO, 32'h0);
		sb("start seen", `ICSM_S_S, 1'b1);
		sb("stop seen", `ICSM_S_P, 1'b0);
		str <= 1;
		wr(`ICSM_OFS_THR, 32'h60);
		sb("tx full", `ICSM_S_TBF, 1'b1);
		sb("tx active", `ICSM_S_TXACT, 1'b1);
		wr(`ICSM_OFS_THR, 32'h11);
		sb("write collision", `ICSM_S_WCOL, 1'b1);
		wev();
		rchk("tx done", `ICSM_OFS_STAT, 32'hc001, 32'h0);
		chk("wire byte", 32'h60, 32'(bm.last_byte));
		str <= 0;
		nack <= 1;
		wr(`ICSM_OFS_THR, 32'h55);
		wev();
		sb("nack status", `ICSM_S_ACKST, 1'b1);
		nack <= 0;
		sb("wcol kept", `ICSM_S_WCOL, 1'b1);
		wr(`ICSM_OFS_STAT, 32'h0);
		sb("wcol clear", `ICSM_S_WCOL, 1'b0);
		tdone("master transmit");
		go(`ICSM_C_RSGO, 32'h0);
		sb("restart seen", `ICSM_S_S, 1'b1);
		rdb <= 8'hc3;
		wr(`ICSM_OFS_THR, 32'h61);
		wev();
		go(`ICSM_C_RXGO, 32'h0);
		sb("rx full", `ICSM_S_RBF, 1'b1);
		rdb <= 8'h3c;
		go(`ICSM_C_ACKGO, 32'h0);
		chk("ack driven", 32'h0, 32'(bm.ack_seen));
		go(`ICSM_C_RXGO, 32'h0);
		go(`ICSM_C_ACKGO, 32'h20);
		chk("nack driven", 32'h1, 32'(bm.ack_seen));
		sb("overflow", `ICSM_S_POV, 1'b1);
		rchk("rx data", `ICSM_OFS_RHR, 32'hff, 32'hc3);
		sb("rx read", `ICSM_S_RBF, 1'b0);
		go(`ICSM_C_STOPGO, 32'h0);
		rchk("stop flags", `ICSM_OFS_STAT, 32'h18, 32'h10);
		tdone("master receive");
		wr(`ICSM_OFS_CTL, EN);
		bm.m_start();
		bm.m_byte(8'h00, ack);
		chk("gc ack", 32'h0, 32'(ack));
		sb("gc seen", `ICSM_S_GC, 1'b1);
		rchk("addr kind", `ICSM_OFS_STAT, 32'h24, 32'h0);
		bm.m_byte(8'h5a, ack);
		sb("data kind", `ICSM_S_DA, 1'b1);
		rchk("slave rx", `ICSM_OFS_RHR, 32'hff, 32'h5a);
		bm.m_stop();
		sb("gc cleared", `ICSM_S_GC, 1'b0);
		bm.m_start();
		bm.m_byte(8'ha5, ack);
		chk("own ack", 32'h0, 32'(ack));
		sb("read dir", `ICSM_S_RW, 1'b1);
		bm.m_stop();
		for (int i = 0; i < 2; i++)
		begin
			wr(`ICSM_OFS_MASK, 32'(1 - i));
			bm.m_start();
			bm.m_byte(8'ha6, ack);
			bm.m_stop();
			chk("mask ack", 32'(i), 32'(ack));
		end
		wr(`ICSM_OFS_OWN, 32'h2a5);
		wr(`ICSM_OFS_CTL, EN | 32'h400);
		bm.m_start();
		bm.m_byte(8'hf4, ack);
		bm.m_byte(8'ha5, ack);
		sb("ten match", `ICSM_S_TEN, 1'b1);
		bm.m_stop();
		sb("ten cleared", `ICSM_S_TEN, 1'b0);
		tdone("slave");
		coll <= 1;
		go(`ICSM_C_STGO, 32'h400);
		wr(`ICSM_OFS_THR, 32'hff);
		wev();
		sb("collision", `ICSM_S_BCL, 1'b1);
		chk("sda freed", 32'h1, 32'(sda_oe_n));
		coll <= 0;
		sb("collision kept", `ICSM_S_BCL, 1'b1);
		wr(`ICSM_OFS_STAT, 32'h0);
		sb("collision clr", `ICSM_S_BCL, 1'b0);
		tdone("collision");
		end_of_test();
	end
endmodule
